/* rtl/fpts_defines.svh */
// constants of the fixed position table sequencer
// Operation
// - power stage only with enable and start
// - table enable with set 0 homes
// - no set runs before first homing
// - homing uses preconfigured homing type
// - table enable runs set at index
// - index bit 0 is least significant
// - set starts after target or immediately
// - jog moves while jog input held
// - running set beats jog requests
// - separate inputs for each jog direction
`ifndef FPTS_DEFINES_SVH
`define FPTS_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define FPTS_OFS_CTRL 8'h00
`define FPTS_OFS_STATUS 8'h04
`define FPTS_OFS_TADDR 8'h08
`define FPTS_OFS_TDATA 8'h0C
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define FPTS_HTYPE_W 4
`define FPTS_HTYPE_RST 4'h0
`define FPTS_COND_BIT 31
`define FPTS_ST_REFUSED 4
`define FPTS_ST_HOMED 3
`define FPTS_SET_HOMING 5'h00
`endif

/* rtl/fpts_pkg.sv */
// types of the fixed position table sequencer
package fpts_pkg;
  typedef enum logic [2:0] {
    FPTS_OFF = 3'b000,
    FPTS_IDLE = 3'b001,
    FPTS_HOMING = 3'b010,
    FPTS_MOVING = 3'b011,
    FPTS_JOG = 3'b100
  } fpts_state_t;
endpackage : fpts_pkg

/* rtl/fpts_set_mem.sv */
// positioning set table memory with registered read
module fpts_set_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array: contents are loaded by software
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : fpts_set_mem

/* rtl/fpts_sequencer.sv */
// fixed position table sequencer top
//
// Chosen here: the register addresses and the strobed register port.
`include "fpts_defines.svh"
module fpts_sequencer import fpts_pkg::*; #(
  parameter int TW = 24,
  parameter int SETS = 32
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic powerStageHwEnable,
  input wire logic startControl,
  input wire logic tableEnable,
  input wire logic setIndexBit0,
  input wire logic setIndexBit1,
  input wire logic setIndexBit2,
  input wire logic setIndexBit3,
  input wire logic setIndexBit4,
  input wire logic jogPositiveRequest,
  input wire logic jogNegativeRequest,
  input wire logic homingDone,
  input wire logic targetReached,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic powerStageOn,
  output logic homingStart,
  output logic [`FPTS_HTYPE_W-1:0] homingType,
  output logic moveStart,
  output logic [TW-1:0] moveTarget,
  output logic jogPositive,
  output logic jogNegative,
  output logic homed
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (TW < 1 || TW > `FPTS_COND_BIT) begin : g_tw_chk
    $error("target width must fit below the start condition bit");
  end
  if (SETS != 32) begin : g_sets_chk
    $error("five index inputs address exactly 32 sets");
  end

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  fpts_state_t state;
  fpts_state_t next_state;
  logic [`FPTS_HTYPE_W-1:0] ctrlHomingType;
  logic [4:0] tableAddr;
  logic refused;
  logic tePrev;
  logic lookupPend;
  logic [4:0] latchedIdx;
  logic pendValid;
  logic [TW-1:0] pendTarget;
  logic [31:0] setWord;

  // set 0 is reserved for the homing run
  function automatic logic isHomingSet(input logic [4:0] idx);
    return idx == `FPTS_SET_HOMING;
  endfunction : isHomingSet

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic [4:0] liveIdx = {setIndexBit4, setIndexBit3, setIndexBit2, setIndexBit1, setIndexBit0};
  wire logic enabled = powerStageHwEnable & startControl;
  wire logic teRise = tableEnable & ~tePrev;
  wire logic wrCtrl = regWr && regAddr == `FPTS_OFS_CTRL;
  wire logic wrStatus = regWr && regAddr == `FPTS_OFS_STATUS;
  wire logic wrTaddr = regWr && regAddr == `FPTS_OFS_TADDR;
  wire logic wrTdata = regWr && regAddr == `FPTS_OFS_TDATA;
  wire logic isHomingReq = lookupPend && isHomingSet(latchedIdx);
  wire logic isSetReq = lookupPend && !isHomingSet(latchedIdx);
  wire logic setRefused = isSetReq && !homed;
  wire logic setAccepted = isSetReq && homed;
  wire logic startsImmediate = setWord[`FPTS_COND_BIT];
  // a set that waits for the target only queues behind a running move
  wire logic setQueued = setAccepted && state == FPTS_MOVING && !startsImmediate && !targetReached;
  wire logic setStartsNow = setAccepted && !setQueued;
  wire logic pendFires = state == FPTS_MOVING && targetReached && pendValid && !lookupPend;
  wire logic jogOne = jogPositiveRequest ^ jogNegativeRequest;
  wire logic [TW-1:0] setTarget = setWord[TW-1:0];
  wire logic [31:0] statusWord = {27'h0, refused, homed, state};
  wire logic [31:0] readMux =
    regAddr == `FPTS_OFS_CTRL ? {28'h0, ctrlHomingType} :
    regAddr == `FPTS_OFS_STATUS ? statusWord :
    regAddr == `FPTS_OFS_TADDR ? {27'h0, tableAddr} : 32'h0;

  // ----------------------------------------
  // set table
  // ----------------------------------------
  fpts_set_mem #(.DEPTH(SETS), .WIDTH(32)) u_mem (
    .clk(mclk),
    .wrEn(wrTdata),
    .wrAddr(tableAddr),
    .wrData(regWdata),
    .rdAddr(liveIdx),
    .rdData(setWord)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      FPTS_OFF: begin
        if (enabled) begin
          next_state = FPTS_IDLE;
        end
      end
      FPTS_IDLE: begin
        if (isHomingReq) begin
          next_state = FPTS_HOMING;
        end else if (setStartsNow) begin
          next_state = FPTS_MOVING;
        end else if (jogOne) begin
          next_state = FPTS_JOG;
        end
      end
      FPTS_HOMING: begin
        if (homingDone) begin
          next_state = FPTS_IDLE;
        end
      end
      FPTS_MOVING: begin
        // jog is not looked at here: the set finishes first
        if (isHomingReq) begin
          next_state = FPTS_HOMING;
        end else if (targetReached && !pendValid && !setAccepted) begin
          next_state = FPTS_IDLE;
        end
      end
      FPTS_JOG: begin
        if (isHomingReq) begin
          next_state = FPTS_HOMING;
        end else if (setStartsNow) begin
          next_state = FPTS_MOVING;
        end else if (!jogOne) begin
          next_state = FPTS_IDLE;
        end
      end
      default: begin
        next_state = FPTS_OFF;
      end
    endcase
    if (!enabled) begin
      next_state = FPTS_OFF;
    end
  end

  // ----------------------------------------
  // next values
  // ----------------------------------------
  // a homing request suppresses any move start of the same cycle
  wire logic next_homingStart = isHomingReq && enabled;
  wire logic next_moveStart = enabled && (setStartsNow || pendFires) && !isHomingReq;
  wire logic next_jogPositive = next_state == FPTS_JOG && jogPositiveRequest;
  wire logic next_jogNegative = next_state == FPTS_JOG && jogNegativeRequest;
  wire logic homingFinished = state == FPTS_HOMING && homingDone && enabled;
  wire logic pendClear = !enabled || isHomingReq || pendFires;
  wire logic pendLoad = setQueued && enabled;
  wire logic refusalSet = setRefused && enabled;
  wire logic refusalClear = wrStatus && regWdata[`FPTS_ST_REFUSED];

  // ----------------------------------------
  // state and request capture
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= FPTS_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tePrev <= 1'b0;
      lookupPend <= 1'b0;
      latchedIdx <= 5'h00;
    end else begin
      tePrev <= tableEnable;
      lookupPend <= teRise && enabled;
      if (teRise) begin
        latchedIdx <= liveIdx;
      end
    end
  end

  // homed is sticky until reset: only power-on forgets the reference
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      homed <= 1'b0;
    end else if (homingFinished) begin
      homed <= 1'b1;
    end
  end

  // one-deep queue, a later waiting set replaces an earlier one
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pendValid <= 1'b0;
      pendTarget <= '0;
    end else begin
      if (pendClear) begin
        pendValid <= 1'b0;
      end
      if (pendLoad) begin
        pendValid <= 1'b1;
        pendTarget <= setTarget;
      end
    end
  end

  // ----------------------------------------
  // outputs to the motion core
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      powerStageOn <= 1'b0;
      homingStart <= 1'b0;
    end else begin
      powerStageOn <= enabled;
      homingStart <= next_homingStart;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      homingType <= `FPTS_HTYPE_RST;
    end else if (isHomingReq) begin
      homingType <= ctrlHomingType;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      moveStart <= 1'b0;
      moveTarget <= '0;
    end else begin
      moveStart <= next_moveStart;
      if (setStartsNow) begin
        moveTarget <= setTarget;
      end else if (pendFires) begin
        moveTarget <= pendTarget;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      jogPositive <= 1'b0;
      jogNegative <= 1'b0;
    end else begin
      jogPositive <= next_jogPositive;
      jogNegative <= next_jogNegative;
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlHomingType <= `FPTS_HTYPE_RST;
      tableAddr <= 5'h00;
    end else begin
      if (wrCtrl) begin
        ctrlHomingType <= regWdata[`FPTS_HTYPE_W-1:0];
      end
      if (wrTaddr) begin
        tableAddr <= regWdata[4:0];
      end
    end
  end

  // new refusal wins over a write-one clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      refused <= 1'b0;
    end else if (refusalSet) begin
      refused <= 1'b1;
    end else if (refusalClear) begin
      refused <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h0;
    end else begin
      regRdata <= regRd ? readMux : 32'h0;
    end
  end
endmodule : fpts_sequencer

/* tb/fpts_sequencer_asserts.sv */
// port assertions of the position table sequencer
module fpts_sequencer_asserts (
  input wire logic mclk, arst_n, powerStageHwEnable, startControl, tableEnable,
  input wire logic setIndexBit0, setIndexBit1, setIndexBit2, setIndexBit3, setIndexBit4,
  input wire logic jogPositiveRequest, jogNegativeRequest, homingDone,
  input wire logic powerStageOn, homingStart, moveStart, jogPositive, jogNegative, homed
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [4:0] idx = {setIndexBit4, setIndexBit3, setIndexBit2, setIndexBit1, setIndexBit0};
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_power_gate: assert property (!(powerStageHwEnable && startControl) |=> !powerStageOn)
    else $error("power stage on without both enables");
  a_power_follow: assert property ((powerStageHwEnable && startControl) [*2] |-> powerStageOn)
    else $error("power stage off with both enables held");
  // enables must stay up to the second edge, a drop cancels the request
  a_home_run: assert property ($rose(tableEnable) && idx == 5'h00 && (powerStageHwEnable && startControl) ##1
    (powerStageHwEnable && startControl) |-> ##1 homingStart)
    else $error("set zero did not start homing");
  a_refuse_set: assert property ($rose(tableEnable) && idx != 5'h00 && !homed |-> ##2 !moveStart)
    else $error("set started before homing");
  a_homed_keep: assert property (homed |=> homed)
    else $error("homed flag dropped");
  a_homed_cause: assert property ($rose(homed) |-> $past(homingDone))
    else $error("homed without homing completion");
  a_jog_single: assert property (!(jogPositive && jogNegative))
    else $error("both jog directions active");
  a_jog_cause: assert property (jogPositive |-> $past(jogPositiveRequest) && !$past(jogNegativeRequest))
    else $error("positive jog without sole request");
  a_start_pulse: assert property (homingStart |=> !homingStart && !moveStart)
    else $error("homing start not a single pulse");
endmodule : fpts_sequencer_asserts
bind fpts_sequencer fpts_sequencer_asserts i_fpts_sequencer_asserts (.*);

/* tb/fpts_motion_core.sv */
// motion core model answering homing and move starts
module fpts_motion_core (
  input wire logic mclk,
  input wire logic homingStart,
  input wire logic moveStart,
  output logic homingDone,
  output logic targetReached
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic homeRun = 1'b0;
  initial homingDone = 1'b0;
  initial targetReached = 1'b0;
  // delay never below six so a queued set really waits
  always @(posedge mclk) begin
    homingDone <= 1'b0;
    targetReached <= 1'b0;
    if (homingStart || moveStart) begin
      cnt <= 6 + $urandom % 12;
      homeRun <= homingStart;
    end else if (cnt == 1) begin
      homingDone <= homeRun;
      targetReached <= !homeRun;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : fpts_motion_core

/* tb/fpts_sequencer_test.sv */
// self-checking bench of the position table sequencer
`include "fpts_defines.svh"
module fpts_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, arst_n, powerStageHwEnable, startControl, tableEnable, regWr, regRd;
  logic jogPositiveRequest, jogNegativeRequest, homingDone, targetReached, rdPend, lastTr;
  logic powerStageOn, homingStart, moveStart, jogPositive, jogNegative, homed;
  logic [4:0] setIndex;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [`FPTS_HTYPE_W-1:0] homingType;
  logic [23:0] moveTarget;
  logic [35:0] expQ[$];
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  fpts_sequencer i_fpts_sequencer (.*, .setIndexBit0(setIndex[0]), .setIndexBit1(setIndex[1]),
    .setIndexBit2(setIndex[2]), .setIndexBit3(setIndex[3]), .setIndexBit4(setIndex[4]));
  fpts_motion_core i_fpts_motion_core (.*);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(string nm, logic [35:0] s, logic [35:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [35:0] pop();
    if (expQ.size() == 0) return 'x;
    return expQ.pop_front();
  endfunction : pop
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic wr(logic [7:0] a, logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    cyc(1);
    regWr <= 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] d);
    expQ.push_back({4'h3, d});
    regAddr <= a;
    regRd <= 1'b1;
    cyc(1);
    regRd <= 1'b0;
    cyc(1);
  endtask : rd
  // index flips right after the rise, the taken set must not follow it
  task automatic trig(logic [4:0] k);
    setIndex <= k;
    tableEnable <= 1'b1;
    cyc(1);
    setIndex <= ~k;
    cyc(1);
    tableEnable <= 1'b0;
    cyc(1);
  endtask : trig
  task automatic waitHi(ref logic s);
    for (int n = 0; n < 60 && s !== 1'b1; n++) cyc(1);
    cyc(1);
  endtask : waitHi
  always @(posedge mclk) begin
    cycles++;
    if (rdPend) chk("regRdata", {4'h3, regRdata}, pop());
    if (homingStart) chk("homingType", {4'h1, 28'(homingType)}, pop());
    if (moveStart) chk("moveTarget", {lastTr ? 4'h4 : 4'h2, 8'h00, moveTarget}, pop());
    rdPend = regRd;
    lastTr = targetReached;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    logic [23:0] t;
    logic [3:0] ht;
    {arst_n, powerStageHwEnable, startControl, tableEnable, regWr, regRd} = 6'h00;
    {jogPositiveRequest, jogNegativeRequest, rdPend, lastTr, setIndex, regAddr, regWdata} = '0;
    void'($urandom(42));
    cyc(20);
    arst_n <= 1'b1;
    cyc(1);
    rd(8'h04, 32'h0);
    powerStageHwEnable <= 1'b1;
    startControl <= 1'b1;
    cyc(2);
    chk("powerStageOn", powerStageOn, 1'b1);
    trig(5'h05);
    cyc(3);
    rd(8'h04, 32'h11);
    wr(8'h04, 32'h10);
    $display("refusal test ended");
    ht = 4'($urandom);
    wr(8'h00, {28'h0, ht});
    expQ.push_back({4'h1, 28'(ht)});
    trig(5'h00);
    waitHi(homingDone);
    rd(8'h04, 32'h09);
    chk("homed", homed, 1'b1);
    $display("homing test ended");
    for (int i = 0; i < 5; i++) begin
      t = 24'($urandom);
      wr(8'h08, 32'(1 << i));
      wr(8'h0C, {8'h80, t});
      expQ.push_back({12'h200, t});
      trig(5'(1 << i));
      waitHi(targetReached);
    end
    wr(8'h08, 32'h2);
    wr(8'h0C, {8'h80, ~t});
    wr(8'h08, 32'h3);
    wr(8'h0C, {8'h00, t});
    expQ.push_back({12'h200, ~t});
    expQ.push_back({12'h400, t});
    trig(5'h02);
    trig(5'h03);
    waitHi(targetReached);
    waitHi(targetReached);
    $display("set test ended");
    expQ.push_back({12'h200, t});
    trig(5'h03);
    jogPositiveRequest <= 1'b1;
    cyc(2);
    chk("jog", {jogPositive, jogNegative}, 2'b00);
    waitHi(targetReached);
    cyc(2);
    chk("jog", {jogPositive, jogNegative}, 2'b10);
    jogPositiveRequest <= 1'b0;
    jogNegativeRequest <= 1'b1;
    cyc(3);
    chk("jog", {jogPositive, jogNegative}, 2'b01);
    jogNegativeRequest <= 1'b0;
    cyc(2);
    chk("jog", {jogPositive, jogNegative}, 2'b00);
    $display("jog test ended");
    rd(8'h10, 32'h0);
    startControl <= 1'b0;
    cyc(2);
    chk("powerStageOn", powerStageOn, 1'b0);
    rd(8'h04, 32'h08);
    cyc(4);
    chk("pending", 36'(expQ.size()), 36'h0);
    $display("power test ended");
    complete_run();
  end
endmodule : fpts_sequencer_test
